// ### verilog/i2c_target_pkg.sv
// package: register map, field layout and bus constants for the i2c target
package i2c_target_pkg;

    // ****************************************************************
    // bus address and register offsets
    // ****************************************************************
    localparam logic [6:0] BUS_ADDRESS = 7'h6C;
    localparam logic [7:0] OFF_SOFT_RESET = 8'h00;
    localparam logic [7:0] OFF_PART_ID = 8'h01;
    localparam logic [7:0] OFF_BIAS_LIMIT = 8'h10;
    localparam logic [7:0] OFF_REF_PTAT = 8'h11;
    localparam logic [7:0] OFF_REF_CTAT = 8'h12;
    localparam logic [7:0] OFF_REF_CTRL = 8'h13;
    localparam logic [7:0] OFF_BIAS_GAIN = 8'h14;
    localparam logic [7:0] OFF_BIAS_THRESH = 8'h15;

    // ****************************************************************
    // reset values and writable bit masks
    // ****************************************************************
    localparam logic [7:0] RST_SOFT_RESET = 8'h00;
    localparam logic [7:0] RST_BIAS_LIMIT = 8'h06;
    localparam logic [7:0] RST_REF_PTAT = 8'h37;
    localparam logic [7:0] RST_REF_CTAT = 8'h49;
    localparam logic [7:0] RST_REF_CTRL = 8'h0A;
    localparam logic [7:0] RST_BIAS_GAIN = 8'h18;
    localparam logic [7:0] RST_BIAS_THRESH = 8'h70;
    localparam logic [7:0] MASK_SOFT_RESET = 8'h01;
    localparam logic [7:0] MASK_BIAS_LIMIT = 8'h0F;
    localparam logic [7:0] MASK_REF_TRIM = 8'h7F;
    localparam logic [7:0] MASK_REF_CTRL = 8'h1F;
    localparam logic [7:0] MASK_BIAS_GAIN = 8'h7F;
    localparam logic [7:0] MASK_BIAS_THRESH = 8'hF0;

    // ****************************************************************
    // field positions and byte width
    // ****************************************************************
    localparam int RESTORE_BIT = 0;
    localparam int REF_DISABLE_BIT = 4;
    localparam int GAIN_BYPASS_BIT = 6;
    localparam int BYTE_BITS = 8;

    // analog control word handed to the bias and reference circuits
    typedef struct packed {
        logic [3:0] biasCurrentLimitField;
        logic [6:0] refPtatTrim;
        logic [6:0] refCtatTrim;
        logic internalReferenceDisable;
        logic [3:0] referenceCurrentTrim;
        logic biasGainBypass;
        logic [5:0] biasGainSetting;
        logic biasTransresistanceOff;
        logic [3:0] biasThresholdSetting;
    } analog_ctrl_type;

    // one register access from the serial engine
    typedef struct packed {
        logic write;
        logic [7:0] addr;
        logic [7:0] data;
    } reg_access_type;

endpackage : i2c_target_pkg

// ### verilog/edge_detect.sv
// edge detector for one sampled line
`timescale 1ns/1ps
module edge_detect (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // sampled line and events
    input wire logic lineIn,
    output logic rise,
    output logic fall,
    output logic level
);
    logic prev_reg;

    // keep the last level; reset as released bus (high)
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            prev_reg <= 1'b1;
        end else begin
            prev_reg <= lineIn;
        end
    end

    assign rise = lineIn & ~prev_reg;
    assign fall = ~lineIn & prev_reg;
    assign level = prev_reg;
endmodule : edge_detect

// ### verilog/config_regs.sv
// configuration register bank with soft restore
`timescale 1ns/1ps
module config_regs #(
    parameter logic [7:0] PART_ID = 8'h5A // arbitrary identifier value
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // access from serial engine
    input wire i2c_target_pkg::reg_access_type access,
    input wire logic accessValid,
    output logic [7:0] readData,
    // analog controls
    output i2c_target_pkg::analog_ctrl_type ctrl
);
    logic [7:0] biasLimit_reg;
    logic [7:0] refPtat_reg;
    logic [7:0] refCtat_reg;
    logic [7:0] refCtrl_reg;
    logic [7:0] biasGain_reg;
    logic [7:0] biasThresh_reg;
    logic restore;

    assign restore = accessValid && access.write
        && access.addr == i2c_target_pkg::OFF_SOFT_RESET
        && access.data[i2c_target_pkg::RESTORE_BIT];

    // writable registers; restore wins over everything
    always_ff @(posedge clk_sys) begin
        if (!rstn || restore) begin
            biasLimit_reg <= i2c_target_pkg::RST_BIAS_LIMIT;
            refPtat_reg <= i2c_target_pkg::RST_REF_PTAT;
            refCtat_reg <= i2c_target_pkg::RST_REF_CTAT;
            refCtrl_reg <= i2c_target_pkg::RST_REF_CTRL;
            biasGain_reg <= i2c_target_pkg::RST_BIAS_GAIN;
            biasThresh_reg <= i2c_target_pkg::RST_BIAS_THRESH;
        end else if (accessValid && access.write) begin
            // unlisted and read-only offsets fall through
            unique case (access.addr)
                i2c_target_pkg::OFF_BIAS_LIMIT: begin
                    biasLimit_reg <= access.data
                        & i2c_target_pkg::MASK_BIAS_LIMIT;
                end
                i2c_target_pkg::OFF_REF_PTAT: begin
                    refPtat_reg <= access.data
                        & i2c_target_pkg::MASK_REF_TRIM;
                end
                i2c_target_pkg::OFF_REF_CTAT: begin
                    refCtat_reg <= access.data
                        & i2c_target_pkg::MASK_REF_TRIM;
                end
                i2c_target_pkg::OFF_REF_CTRL: begin
                    refCtrl_reg <= access.data
                        & i2c_target_pkg::MASK_REF_CTRL;
                end
                i2c_target_pkg::OFF_BIAS_GAIN: begin
                    biasGain_reg <= access.data
                        & i2c_target_pkg::MASK_BIAS_GAIN;
                end
                i2c_target_pkg::OFF_BIAS_THRESH: begin
                    biasThresh_reg <= access.data
                        & i2c_target_pkg::MASK_BIAS_THRESH;
                end
                default: begin
                end
            endcase
        end
    end

    // read mux; the restore bit is self clearing so it reads zero
    always_comb begin
        unique case (access.addr)
            i2c_target_pkg::OFF_SOFT_RESET: begin
                readData = i2c_target_pkg::RST_SOFT_RESET;
            end
            i2c_target_pkg::OFF_PART_ID: readData = PART_ID;
            i2c_target_pkg::OFF_BIAS_LIMIT: readData = biasLimit_reg;
            i2c_target_pkg::OFF_REF_PTAT: readData = refPtat_reg;
            i2c_target_pkg::OFF_REF_CTAT: readData = refCtat_reg;
            i2c_target_pkg::OFF_REF_CTRL: readData = refCtrl_reg;
            i2c_target_pkg::OFF_BIAS_GAIN: readData = biasGain_reg;
            i2c_target_pkg::OFF_BIAS_THRESH: readData = biasThresh_reg;
            default: readData = 8'h00;
        endcase
    end

    // field breakout toward the analog side
    always_comb begin
        ctrl.biasCurrentLimitField = biasLimit_reg[3:0];
        ctrl.refPtatTrim = refPtat_reg[6:0];
        ctrl.refCtatTrim = refCtat_reg[6:0];
        ctrl.internalReferenceDisable =
            refCtrl_reg[i2c_target_pkg::REF_DISABLE_BIT];
        ctrl.referenceCurrentTrim = refCtrl_reg[3:0];
        ctrl.biasGainBypass = biasGain_reg[i2c_target_pkg::GAIN_BYPASS_BIT];
        ctrl.biasGainSetting = biasGain_reg[5:0];
        // zero gain also forces it off
        ctrl.biasTransresistanceOff = ctrl.biasGainBypass
            || (ctrl.biasGainSetting == 6'h00);
        ctrl.biasThresholdSetting = biasThresh_reg[7:4];
    end
endmodule : config_regs

// ### verilog/i2c_config_target.sv
// i2c target serial engine with its configuration register bank
`timescale 1ns/1ps

module i2c_config_target #(
    parameter logic [7:0] PART_ID = 8'h5A // arbitrary identifier value
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // serial bus pins
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    // analog controls
    output i2c_target_pkg::analog_ctrl_type ctrl,
    // status
    output logic busy
);
    // ****************************************************************
    // state encoding
    // ****************************************************************
    typedef enum logic [5:0] {
        IDLE = 6'b00_0001,
        RECV = 6'b00_0010,
        ACK = 6'b00_0100,
        SEND = 6'b00_1000,
        CHECK = 6'b01_0000,
        WAIT = 6'b10_0000
    } state_type;

    // which byte the receiver is collecting
    typedef enum logic [2:0] {
        PH_ADDR = 3'b001,
        PH_REG = 3'b010,
        PH_DATA = 3'b100
    } phase_type;

    state_type state_reg;
    phase_type phase_reg;
    logic [7:0] shift_reg;
    logic [3:0] bitCount_reg;
    logic [7:0] regAddr_reg;
    logic readMode_reg;
    logic sdaOe_reg;
    logic busy_reg;
    i2c_target_pkg::analog_ctrl_type ctrl_reg;
    i2c_target_pkg::analog_ctrl_type ctrlNext;
    i2c_target_pkg::reg_access_type access;
    logic accessValid;
    logic [7:0] readData;
    logic sclRise, sclFall, sclLevel;
    logic sdaRise, sdaFall, sdaLevel;
    logic startCond, stopCond;
    logic byteDone;
    logic [7:0] rxByte;

    // ****************************************************************
    // pin event detection
    // ****************************************************************
    edge_detect sclEdges (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .lineIn(sclIn),
        .rise(sclRise),
        .fall(sclFall),
        .level(sclLevel)
    );

    edge_detect sdaEdges (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .lineIn(sdaIn),
        .rise(sdaRise),
        .fall(sdaFall),
        .level(sdaLevel)
    );

    // start and stop: sda moves while scl held high
    assign startCond = sdaFall && sclLevel && sclIn;
    assign stopCond = sdaRise && sclLevel && sclIn;

    // msb first, new bit enters at lsb
    assign rxByte = {shift_reg[6:0], sdaIn};
    assign byteDone = sclRise && (bitCount_reg == 4'd7);

    // ****************************************************************
    // register bank
    // ****************************************************************
    // one access per byte: write on a data byte, read address live
    assign access.write = (state_reg == RECV) && (phase_reg == PH_DATA)
        && byteDone && !startCond && !stopCond;
    assign access.addr = regAddr_reg;
    assign access.data = rxByte;
    assign accessValid = access.write;

    config_regs #(
        .PART_ID(PART_ID)
    ) regBank (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .access(access),
        .accessValid(accessValid),
        .readData(readData),
        .ctrl(ctrlNext)
    );

    // ****************************************************************
    // serial protocol engine
    // ****************************************************************
    // bit sampling on scl rise, sda changes on scl fall
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            state_reg <= IDLE;
            phase_reg <= PH_ADDR;
            shift_reg <= 8'h00;
            bitCount_reg <= 4'd0;
            regAddr_reg <= 8'h00;
            readMode_reg <= 1'b0;
        end else if (stopCond) begin
            state_reg <= IDLE;
        end else if (startCond) begin
            // start (or repeated start) restarts address phase
            state_reg <= RECV;
            phase_reg <= PH_ADDR;
            bitCount_reg <= 4'd0;
        end else begin
            unique case (state_reg)
                IDLE: begin
                end
                RECV: begin
                    if (sclRise) begin
                        shift_reg <= rxByte;
                        bitCount_reg <= bitCount_reg + 4'd1;
                    end
                    if (byteDone) begin
                        unique case (phase_reg)
                            PH_ADDR: begin
                                if (rxByte[7:1]
                                    == i2c_target_pkg::BUS_ADDRESS) begin
                                    readMode_reg <= rxByte[0];
                                    state_reg <= ACK;
                                end else begin
                                    state_reg <= WAIT;
                                end
                            end
                            PH_REG: begin
                                regAddr_reg <= rxByte;
                                state_reg <= ACK;
                            end
                            PH_DATA: begin
                                state_reg <= ACK;
                            end
                            default: state_reg <= IDLE;
                        endcase
                    end
                end
                ACK: begin
                    // ack bit spans one scl pulse, left on its fall
                    if (sclFall && bitCount_reg == 4'd9) begin
                        bitCount_reg <= 4'd0;
                        if (phase_reg == PH_ADDR && readMode_reg) begin
                            state_reg <= SEND;
                            shift_reg <= readData;
                        end else begin
                            state_reg <= RECV;
                            // step address after a data byte
                            if (phase_reg == PH_DATA) begin
                                regAddr_reg <= regAddr_reg + 8'd1;
                            end
                            phase_reg <= (phase_reg == PH_ADDR)
                                ? PH_REG : PH_DATA;
                        end
                    end else if (sclFall) begin
                        bitCount_reg <= 4'd9;
                    end
                end
                SEND: begin
                    // shift next bit out after each falling edge
                    if (sclFall) begin
                        shift_reg <= {shift_reg[6:0], 1'b0};
                        bitCount_reg <= bitCount_reg + 4'd1;
                        if (bitCount_reg == 4'd7) begin
                            state_reg <= CHECK;
                        end
                    end
                end
                CHECK: begin
                    // controller ack or nack on ninth clock
                    if (sclRise) begin
                        if (sdaIn) begin
                            state_reg <= WAIT;
                        end else begin
                            regAddr_reg <= regAddr_reg + 8'd1;
                            bitCount_reg <= 4'd8;
                        end
                    end else if (sclFall && bitCount_reg == 4'd8) begin
                        state_reg <= SEND;
                        bitCount_reg <= 4'd0;
                        shift_reg <= readData;
                    end
                end
                WAIT: begin
                end
                default: state_reg <= IDLE;
            endcase
        end
    end

    // ****************************************************************
    // sda driver
    // ****************************************************************
    // open drain, output value is always low
    assign sdaOut = 1'b0;

    // enable decided one clock after the scl fall, but the ack release on the fall clock itself; both inside the low phase
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            sdaOe_reg <= 1'b0;
        end else if (startCond || stopCond) begin
            sdaOe_reg <= 1'b0;
        end else begin
            unique case (state_reg)
                // pull low from the eighth fall to the ninth
                ACK: sdaOe_reg <= (bitCount_reg == 4'd9) && !sclFall;
                SEND: sdaOe_reg <= ~shift_reg[7];
                default: sdaOe_reg <= 1'b0;
            endcase
        end
    end
    assign sdaOe = sdaOe_reg;

    // ****************************************************************
    // registered outputs
    // ****************************************************************
    // limit field and others pass out through a register
    // gain field carried whole with its bypass meaning
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            ctrl_reg <= '0;
            busy_reg <= 1'b0;
        end else begin
            ctrl_reg <= ctrlNext;
            busy_reg <= (state_reg != IDLE) && (state_reg != WAIT);
        end
    end
    assign ctrl = ctrl_reg;
    assign busy = busy_reg;

    // rate limit is the controller's; 125 mhz oversamples it
    // one engine serves single and burst access alike
endmodule : i2c_config_target

// ### test/i2c_controller_model.sv
// bus controller model: clocks scl and pulls sda low or releases it
`timescale 1ns/1ps
module i2c_controller_model #(
    parameter int QUARTER = 80
) (
    // clock
    input wire logic clk_sys,
    // bus wires
    input wire logic sdaLine,
    output logic sclOut,
    output logic sdaPull
);
    // bus idles released with scl high
    initial begin
        sclOut = 1'b1;
        sdaPull = 1'b0;
    end
    task automatic waitQ();
        repeat (QUARTER) @(posedge clk_sys);
    endtask : waitQ
    // four quarters of 80 clocks keep scl under the limit
    task automatic bitIo(input logic txBit, output logic rxBit);
        sclOut <= 1'b0;
        waitQ();
        // a released line reads high through the pull-up
        sdaPull <= ~txBit;
        waitQ();
        sclOut <= 1'b1;
        waitQ();
        rxBit = sdaLine; // sampled mid-high, well away from edges
        waitQ();
    endtask : bitIo
    // start, also serves as repeated start
    task automatic startCond();
        sclOut <= 1'b0;
        waitQ();
        sdaPull <= 1'b0;
        waitQ();
        sclOut <= 1'b1;
        waitQ();
        sdaPull <= 1'b1;
        waitQ();
    endtask : startCond
    task automatic stopCond();
        sclOut <= 1'b0;
        waitQ();
        sdaPull <= 1'b1;
        waitQ();
        sclOut <= 1'b1;
        waitQ();
        sdaPull <= 1'b0;
        waitQ();
    endtask : stopCond
    // eight bits msb first, then the ninth bit
    task automatic xferByte(input logic [7:0] txByte, input logic ackOut,
            output logic [7:0] rxByte, output logic ackIn);
        for (int i = 7; i >= 0; i--) begin
            bitIo(txByte[i], rxByte[i]);
        end
        bitIo(ackOut, ackIn);
    endtask : xferByte
endmodule : i2c_controller_model

// ### test/i2c_config_target_asserts.sv
// checker: timing and value relations at the target's ports
`timescale 1ns/1ps
module i2c_config_target_asserts (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // bus pins
    input wire logic sclIn,
    input wire logic sdaIn,
    input wire logic sdaOut,
    input wire logic sdaOe,
    // outputs
    input wire i2c_target_pkg::analog_ctrl_type ctrl,
    input wire logic busy
);
    logic sclPrev;
    logic sdaPrev;
    logic [2:0] rstAge;
    // previous bus samples, to see edges of scl and sda
    always_ff @(posedge clk_sys) begin
        sclPrev <= sclIn;
        sdaPrev <= sdaIn;
    end
    // saturating age since reset release; ctrl is all zero right after reset
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            rstAge <= 3'h0;
        end else if (rstAge != 3'h7) begin
            rstAge <= rstAge + 3'h1;
        end
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);
    sequence sclHeld;
        sclIn && sclPrev;
    endsequence
    sequence stopSeen;
        sclHeld ##0 (sdaIn && !sdaPrev);
    endsequence
    a_sda_open_drain: assert property (sdaOut == 1'b0)
        else $error("sda output value not low");
    a_oe_rise_low: assert property ($rose(sdaOe) |-> !sclIn && !sclPrev)
        else $error("sda pull started outside scl low");
    a_oe_fall_low: assert property ($fell(sdaOe) |-> !sclIn && !sclPrev)
        else $error("sda pull ended outside scl low");
    a_oe_steady_high: assert property (sclHeld |-> $stable(sdaOe))
        else $error("sda pull changed while scl high");
    a_busy_after_stop: assert property (stopSeen |-> ##[1:3] !busy)
        else $error("busy held after stop");
    a_off_formula: assert property (rstAge == 3'h7 |->
        ctrl.biasTransresistanceOff ==
        (ctrl.biasGainBypass || ctrl.biasGainSetting == 6'h00))
        else $error("transresistance off flag wrong");
    a_ctrl_quiet_idle: assert property (
        rstAge == 3'h7 && !$stable(ctrl) |-> busy || $past(busy))
        else $error("ctrl changed outside a transaction");
    a_reset_bias: assert property (rstAge == 3'h3 |->
        ctrl.biasCurrentLimitField == 4'h6 && ctrl.biasGainSetting == 6'h18
        && !ctrl.biasGainBypass && ctrl.biasThresholdSetting == 4'h7)
        else $error("bias defaults wrong after reset");
    a_reset_ref: assert property (rstAge == 3'h3 |->
        ctrl.refPtatTrim == 7'h37 && ctrl.refCtatTrim == 7'h49
        && !ctrl.internalReferenceDisable && ctrl.referenceCurrentTrim == 4'hA)
        else $error("reference defaults wrong after reset");
endmodule : i2c_config_target_asserts
bind i2c_config_target i2c_config_target_asserts checker0 (
    .clk_sys(clk_sys), .rstn(rstn), .sclIn(sclIn), .sdaIn(sdaIn),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .ctrl(ctrl), .busy(busy)
);

// ### test/i2c_target_config_registers_bench.sv
// bench: reference register model and bus scenarios for the target
`timescale 1ns/1ps
module i2c_target_config_registers_bench;
    localparam logic [7:0] PART_VALUE = 8'hA3; // arbitrary identifier value
    logic clk_sys;
    logic rstn;
    logic sclLine;
    logic sdaLine;
    logic sdaOut;
    logic sdaOe;
    logic hostPull;
    logic busy;
    i2c_target_pkg::analog_ctrl_type ctrl;
    logic [7:0] regMem [0:255];
    int errCount;
    int totalChecks;
    assign sdaLine = ~((sdaOe & ~sdaOut) | hostPull);
    i2c_config_target #(.PART_ID(PART_VALUE)) DUT (
        .clk_sys(clk_sys), .rstn(rstn), .sclIn(sclLine), .sdaIn(sdaLine),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .ctrl(ctrl), .busy(busy)
    );
    i2c_controller_model #(.QUARTER(80)) host (
        .clk_sys(clk_sys), .sdaLine(sdaLine), .sclOut(sclLine),
        .sdaPull(hostPull)
    );
    // ****************************************************************
    // reference model and compares
    // ****************************************************************
    task automatic restoreModel();
        for (int a = 0; a < 256; a++) begin
            regMem[a] = 8'h00;
        end
        regMem[8'h01] = PART_VALUE;
        regMem[8'h10] = 8'h06;
        regMem[8'h11] = 8'h37;
        regMem[8'h12] = 8'h49;
        regMem[8'h13] = 8'h0A;
        regMem[8'h14] = 8'h18;
        regMem[8'h15] = 8'h70;
    endtask : restoreModel
    // read-only and unlisted places keep their contents
    task automatic modelWrite(input logic [7:0] addr, input logic [7:0] data);
        case (addr)
            8'h00: if (data[0]) restoreModel();
            8'h10: regMem[addr] = data & i2c_target_pkg::MASK_BIAS_LIMIT;
            8'h11, 8'h12: regMem[addr] = data & i2c_target_pkg::MASK_REF_TRIM;
            8'h13: regMem[addr] = data & i2c_target_pkg::MASK_REF_CTRL;
            8'h14: regMem[addr] = data & i2c_target_pkg::MASK_BIAS_GAIN;
            8'h15: regMem[addr] = data & i2c_target_pkg::MASK_BIAS_THRESH;
            default: ;
        endcase
    endtask : modelWrite
    task automatic checkByte(input string what, input logic [7:0] exp,
            input logic [7:0] got);
        totalChecks++;
        if (got !== exp) begin
            errCount++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : checkByte
    task automatic checkBit(input string what, input logic exp, input logic got);
        totalChecks++;
        if (got !== exp) begin
            errCount++;
            $display("ERROR %s expected %b seen %b", what, exp, got);
        end
    endtask : checkBit
    task automatic checkCtrl(input string what);
        i2c_target_pkg::analog_ctrl_type c;
        c.biasCurrentLimitField = regMem[8'h10][3:0];
        c.refPtatTrim = regMem[8'h11][6:0];
        c.refCtatTrim = regMem[8'h12][6:0];
        c.internalReferenceDisable = regMem[8'h13][4];
        c.referenceCurrentTrim = regMem[8'h13][3:0];
        c.biasGainBypass = regMem[8'h14][6];
        c.biasGainSetting = regMem[8'h14][5:0];
        c.biasTransresistanceOff = c.biasGainBypass || c.biasGainSetting == 0;
        c.biasThresholdSetting = regMem[8'h15][7:4];
        totalChecks++;
        if (ctrl !== c) begin
            errCount++;
            $display("ERROR %s expected %h seen %h", what, c, ctrl);
        end
    endtask : checkCtrl
    // ****************************************************************
    // transactions
    // ****************************************************************
    task automatic openWrite(input logic [7:0] addr);
        logic [7:0] rx;
        logic ack;
        host.startCond();
        host.xferByte({7'h6C, 1'b0}, 1'b1, rx, ack);
        checkBit("write address ack", 1'b0, ack);
        host.xferByte(addr, 1'b1, rx, ack);
        checkBit("register address ack", 1'b0, ack);
    endtask : openWrite
    task automatic writeRegs(input logic [7:0] addr, input logic [7:0] data[$]);
        logic [7:0] rx;
        logic ack;
        openWrite(addr);
        foreach (data[i]) begin
            host.xferByte(data[i], 1'b1, rx, ack);
            checkBit("data ack", 1'b0, ack);
            checkByte("sda during write data", data[i], rx);
            modelWrite(addr + 8'(i), data[i]);
        end
        host.stopCond();
    endtask : writeRegs
    task automatic readRegs(input logic [7:0] addr, input int count);
        logic [7:0] rx;
        logic ack;
        openWrite(addr);
        host.startCond();
        host.xferByte({7'h6C, 1'b1}, 1'b1, rx, ack);
        checkBit("read address ack", 1'b0, ack);
        for (int i = 0; i < count; i++) begin
            host.xferByte(8'hFF, i == count - 1, rx, ack);
            checkByte("read data", regMem[addr + 8'(i)], rx);
        end
        host.stopCond();
    endtask : readRegs
    task automatic conclude();
        $display("checks %0d errors %0d", totalChecks, errCount);
        if (errCount == 0 && totalChecks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : conclude
    // clock, 8 ns period
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    // watchdog: about 86k cycles of traffic, cut off beyond that
    initial begin
        repeat (98000) @(posedge clk_sys);
        errCount++;
        conclude();
    end
    // main sequence
    initial begin
        logic [7:0] burst[$];
        logic [7:0] rx;
        logic ack;
        int seedDummy;
        rstn = 1'b0;
        errCount = 0;
        totalChecks = 0;
        restoreModel();
        seedDummy = $urandom(27);
        repeat (4) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (4) @(posedge clk_sys);
        checkCtrl("ctrl after reset");
        burst = {8'h40 | 8'($urandom_range(0, 63))};
        writeRegs(8'h14, burst);
        checkCtrl("ctrl after bypass write");
        burst = {};
        for (int i = 0; i < 6; i++) begin
            burst.push_back(8'($urandom));
        end
        burst[4] = 8'h80; // reserved bit set, gain zero, bypass clear
        writeRegs(8'h10, burst);
        checkCtrl("ctrl after burst write");
        readRegs(8'h14, 3);
        burst = {8'($urandom)};
        writeRegs(8'h01, burst);
        readRegs(8'h01, 1);
        host.startCond();
        host.xferByte({7'h2A, 1'b0}, 1'b1, rx, ack);
        checkBit("foreign address ack", 1'b1, ack);
        checkBit("busy on foreign address", 1'b0, busy);
        host.stopCond();
        burst = {8'h01};
        writeRegs(8'h00, burst);
        checkCtrl("ctrl after restore");
        conclude();
    end
endmodule : i2c_target_config_registers_bench
